/* igw_device.sv */
/*
  Device end: control registers, gate outputs, watchdog, fault flags and
  overcurrent timer.
  Assumes link requests and analog fault inputs; fault inputs are async.
*/
// Summary of operation
// - Zero action bits: gates follow control bits only
// - Host: bridge on is on=1, off=0
// - Host: bridge off is on=0, off=0
// - Host: reverse on is on=1, off=0
// - Host: reverse off is on=0, off=0
// - Host: phase on is on=1, off=0
// - Host: phase off is on=0, off=1
// - Gate undervoltage inputs raise per-driver flags only while that gate is on
// - Host polls undervoltage flags while gate on
// - Watchdog enabled at reset, 1310 ms period
// - No transaction within 1310 ms gives timeout
// - Gap beyond timeout raises watchdog fault
// - Watchdog enable resets to one
// - Host disables watchdog by write then read
// - Watchdog fault latched until written one
// - Three-bit period field always writable
// - Charge pump enable resets zero, runs when set
// - Fault action bits reset to zero
// - Overcurrent timer lasts 4^p*(n+1) clocks
// - Host: timer enable with bridge on and off
// - Host clears fault and retries while charging
// - Status flags clear by writing one
// - Action bit set: overcurrent turns bridge off
// - Action bit clear: flag only, gates unchanged
module igw_device #(
  parameter longint unsigned WD_BASE_CYC = igw_pkg::WD_DEFAULT_CYC
) (
  // Clock and reset
  input  wire logic   mclk_i,
  input  wire logic   nrst_i,
  // Link
  igw_link_if.device  link,
  // Analog monitor inputs
  input  wire logic   bridge_oc_i,
  input  wire logic   bridge_gate_uv_i,
  input  wire logic   reverse_gate_uv_i,
  input  wire logic [2:0] phase_gate_uv_i,
  // Gate and status outputs
  output logic        bridge_gate_output_o,
  output logic        reverse_gate_output_o,
  output logic [2:0]  phase_gate_output_o,
  output logic        charge_pump_run_o,
  output logic        diagnostic_pin_n_o
);
  localparam int NF = 6;

  // Synchroniser for async fault inputs
  logic [NF-1:0] raw, s1_q, s2_q;
  assign raw = {phase_gate_uv_i, reverse_gate_uv_i, bridge_gate_uv_i,
                bridge_oc_i};
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  logic oc_s;
  logic [2:0] uv_ph_s;
  logic uv_brg_s, uv_rev_s;
  assign oc_s     = s2_q[0];
  assign uv_brg_s = s2_q[1];
  assign uv_rev_s = s2_q[2];
  assign uv_ph_s  = s2_q[5:3];

  function automatic longint unsigned wd_limit(input logic [2:0] p);
    wd_limit = WD_BASE_CYC >> p;
  endfunction : wd_limit

  function automatic logic [9:0] pre_len(input logic [1:0] p);
    pre_len = 10'h001 << (2 * p);
  endfunction : pre_len

  logic [15:0] endis1_q, endis1_d, endis2_q, endis2_d;
  logic [15:0] cfg1_q, cfg1_d, octc_q, octc_d;
  logic [15:0] stat_q, stat_d;
  logic        brg_q, brg_d, rev_q, rev_d;
  logic [2:0]  ph_q, ph_d;
  logic [31:0] wd_cnt_q, wd_cnt_d;
  logic [9:0]  pre_q, pre_d;
  logic [7:0]  tmr_q, tmr_d;
  logic        tmr_run_q, tmr_run_d;
  logic        rv_q, rv_d;
  logic [15:0] rd_q, rd_d;
  logic        wr_ev;

  assign wr_ev = link.req & link.wr;

  always_comb begin
    endis1_d = endis1_q;
    endis2_d = endis2_q;
    cfg1_d   = cfg1_q;
    octc_d   = octc_q;
    stat_d   = stat_q;
    brg_d    = brg_q;
    rev_d    = rev_q;
    ph_d     = ph_q;
    wd_cnt_d = wd_cnt_q;
    pre_d    = pre_q;
    tmr_d    = tmr_q;
    tmr_run_d = tmr_run_q;
    rv_d     = link.req & ~link.wr;
    rd_d     = 16'h0000;
    if (link.req & ~link.wr) begin
      case (link.addr)
        igw_pkg::ADR_STATUS0: rd_d = stat_q;
        igw_pkg::ADR_ENDIS1:  rd_d = endis1_q;
        igw_pkg::ADR_ENDIS2:  rd_d = endis2_q;
        igw_pkg::ADR_CONFIG1: rd_d = cfg1_q;
        igw_pkg::ADR_OCTCFG:  rd_d = octc_q;
        default:              rd_d = 16'h0000;
      endcase
    end
    // Status clear by writing one; hardware set below wins
    if (wr_ev && link.addr == igw_pkg::ADR_STATUS0)
      stat_d = stat_q & ~link.wdata;
    if (wr_ev) begin
      case (link.addr)
        igw_pkg::ADR_ENDIS1: begin
          endis1_d = link.wdata;
          // Gate control from on/off pairs
          if (link.wdata[igw_pkg::BIT_BRG_ON])
            brg_d = 1'b1;
          else if (!link.wdata[igw_pkg::BIT_BRG_OFF])
            brg_d = 1'b0;
          if (link.wdata[igw_pkg::BIT_REV_ON] &&
              !link.wdata[igw_pkg::BIT_REV_OFF])
            rev_d = 1'b1;
          else if (!link.wdata[igw_pkg::BIT_REV_ON] &&
                   !link.wdata[igw_pkg::BIT_REV_OFF])
            rev_d = 1'b0;
          for (int i = 0; i < 3; i++) begin
            if (link.wdata[igw_pkg::BIT_PH_ON+i] &&
                !link.wdata[igw_pkg::BIT_PH_OFF+i])
              ph_d[i] = 1'b1;
            else if (!link.wdata[igw_pkg::BIT_PH_ON+i] &&
                     link.wdata[igw_pkg::BIT_PH_OFF+i])
              ph_d[i] = 1'b0;
          end
          // Timed charging start
          if (link.wdata[igw_pkg::BIT_TMR_EN] &&
              link.wdata[igw_pkg::BIT_BRG_ON]) begin
            tmr_run_d = 1'b1;
            tmr_d     = octc_q[igw_pkg::TMR_CNT_LSB +: 8];
            pre_d     = pre_len(octc_q[igw_pkg::TMR_PRE_LSB +: 2]);
          end
        end
        igw_pkg::ADR_ENDIS2:  endis2_d = link.wdata;
        igw_pkg::ADR_CONFIG1: cfg1_d = link.wdata;
        igw_pkg::ADR_OCTCFG:  octc_d = link.wdata;
        default: ;
      endcase
    end
    // Overcurrent timer: 4^p*(n+1) clocks
    if (tmr_run_q) begin
      if (pre_q > 10'h001) begin
        pre_d = pre_q - 10'h001;
      end else begin
        pre_d = pre_len(octc_q[igw_pkg::TMR_PRE_LSB +: 2]);
        if (tmr_q == 8'h00)
          tmr_run_d = 1'b0;
        else
          tmr_d = tmr_q - 8'h01;
      end
    end
    // Overcurrent fault: flag always, gate only with action bit
    if (tmr_run_q && tmr_q == 8'h00 && pre_q <= 10'h001) begin
      stat_d[igw_pkg::BIT_F_OC] = 1'b1;
      if (endis2_q[igw_pkg::BIT_BRG_OC_ACT])
        brg_d = 1'b0;
    end
    if (oc_s) begin
      stat_d[igw_pkg::BIT_F_OC] = 1'b1;
      if (endis2_q[igw_pkg::BIT_BRG_OC_ACT])
        brg_d = 1'b0;
    end
    // Gate undervoltage flags
    if (uv_brg_s && brg_q) stat_d[igw_pkg::BIT_F_UV_BRG] = 1'b1;
    if (uv_rev_s && rev_q) stat_d[igw_pkg::BIT_F_UV_REV] = 1'b1;
    for (int i = 0; i < 3; i++)
      if (uv_ph_s[i] && ph_q[i]) stat_d[igw_pkg::BIT_F_UV_PH+i] = 1'b1;
    // Watchdog
    if (link.req || !endis1_q[igw_pkg::BIT_WD_EN]) begin
      wd_cnt_d = 32'h0000_0000;
    end else if (64'(wd_cnt_q) + 64'd1 >=
                 wd_limit(cfg1_q[igw_pkg::WD_PER_LSB +: 3])) begin
      stat_d[igw_pkg::BIT_F_WD] = 1'b1;
      wd_cnt_d = 32'h0000_0000;
    end else begin
      wd_cnt_d = wd_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      endis1_q  <= igw_pkg::ENDIS1_RST;
      endis2_q  <= igw_pkg::ENDIS2_RST;
      cfg1_q    <= igw_pkg::CONFIG1_RST;
      octc_q    <= igw_pkg::OCTCFG_RST;
      stat_q    <= 16'h0000;
      brg_q     <= 1'b0;
      rev_q     <= 1'b0;
      ph_q      <= 3'h0;
      wd_cnt_q  <= 32'h0000_0000;
      pre_q     <= 10'h001;
      tmr_q     <= 8'h00;
      tmr_run_q <= 1'b0;
      rv_q      <= 1'b0;
      rd_q      <= 16'h0000;
      charge_pump_run_o     <= 1'b0;
      diagnostic_pin_n_o    <= 1'b1;
    end else begin
      endis1_q  <= endis1_d;
      endis2_q  <= endis2_d;
      cfg1_q    <= cfg1_d;
      octc_q    <= octc_d;
      stat_q    <= stat_d;
      brg_q     <= brg_d;
      rev_q     <= rev_d;
      ph_q      <= ph_d;
      wd_cnt_q  <= wd_cnt_d;
      pre_q     <= pre_d;
      tmr_q     <= tmr_d;
      tmr_run_q <= tmr_run_d;
      rv_q      <= rv_d;
      rd_q      <= rd_d;
      charge_pump_run_o  <= endis1_q[igw_pkg::BIT_CP_EN];
      diagnostic_pin_n_o <= ~(|stat_q);
    end
  end

  assign bridge_gate_output_o  = brg_q;
  assign reverse_gate_output_o = rev_q;
  assign phase_gate_output_o   = ph_q;
  assign link.rvalid = rv_q;
  assign link.rdata  = rd_q;
endmodule : igw_device

/* igw_pkg.sv */
/*
  Shared constants for the isolator gate enable and watchdog block.
  Assumes a single 200 MHz clock shared by device and controller ends.
*/
package igw_pkg;
  // Clock and watchdog timing
  localparam int unsigned CLK_MHZ        = 200;
  localparam int unsigned WD_DEFAULT_MS  = 1310;
  localparam longint unsigned WD_DEFAULT_CYC =
    longint'(WD_DEFAULT_MS) * 1000 * CLK_MHZ;
  // Register addresses on the link (5-bit)
  localparam logic [4:0] ADR_STATUS0   = 5'h00;
  localparam logic [4:0] ADR_ENDIS1    = 5'h01;
  localparam logic [4:0] ADR_ENDIS2    = 5'h02;
  localparam logic [4:0] ADR_CONFIG1   = 5'h03;
  localparam logic [4:0] ADR_OCTCFG    = 5'h04;
  // ENABLE/DISABLE_1 fields
  localparam int BIT_BRG_ON   = 0;
  localparam int BIT_BRG_OFF  = 1;
  localparam int BIT_REV_ON   = 2;
  localparam int BIT_REV_OFF  = 3;
  localparam int BIT_PH_ON    = 4;  // 4..6 phases a,b,c
  localparam int BIT_PH_OFF   = 7;  // 7..9 phases a,b,c
  localparam int BIT_WD_EN    = 10;
  localparam int BIT_CP_EN    = 11;
  localparam int BIT_TMR_EN   = 12;
  localparam logic [15:0] ENDIS1_RST = 16'h0400;
  // ENABLE/DISABLE_2 fields
  localparam int BIT_BRG_OC_ACT = 0;
  localparam logic [15:0] ENDIS2_RST = 16'h0000;
  // STATUS_0 fields
  localparam int BIT_F_WD      = 0;
  localparam int BIT_F_OC      = 1;
  localparam int BIT_F_UV_BRG  = 2;
  localparam int BIT_F_UV_REV  = 3;
  localparam int BIT_F_UV_PH   = 4;  // 4..6
  // CONFIG_1 and timer config fields
  localparam logic [15:0] CONFIG1_RST = 16'h0000;
  localparam logic [15:0] OCTCFG_RST  = 16'h0000;
  localparam int WD_PER_LSB  = 0;
  localparam int TMR_CNT_LSB = 0;
  localparam int TMR_PRE_LSB = 8;
  // Link command word layout
  localparam int LINK_W = 22;
endpackage : igw_pkg

/* igw_link_if.sv */
/*
  Word-level link between controller and device.
  Assumes both ends run on the same clock; one word per strobe.
*/
interface igw_link_if;
  logic        req;
  logic        wr;
  logic [4:0]  addr;
  logic [15:0] wdata;
  logic        rvalid;
  logic [15:0] rdata;
  modport device (input req, wr, addr, wdata, output rvalid, rdata);
  modport ctrl   (output req, wr, addr, wdata, input rvalid, rdata);
endinterface : igw_link_if

/* igw_ctrl.sv */
/*
  Controller end: forwards software register accesses onto the link.
  Assumes a plain strobe port on the user side, one cycle read latency.
*/
module igw_ctrl (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  // Software port
  input  wire logic [4:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [15:0]      rdata_o,
  // Link
  igw_link_if.ctrl         link
);
  // Requests pass straight through; host ..
  // by the words software writes
  assign link.req   = wr_i | rd_i;
  assign link.wr    = wr_i;
  assign link.addr  = addr_i;
  assign link.wdata = wdata_i;
  assign rdata_o    = link.rdata;
endmodule : igw_ctrl

/* igw_props.sv */
/*
  Checker for the link and the gate outputs of the igw block.
  Assumes an instance beside the link interface in the testbench.
*/
module igw_props (
  // Clock, reset and link
  input wire logic        mclk_i,
  input wire logic        nrst_i,
  input wire logic        req,
  input wire logic        wr,
  input wire logic [4:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        rvalid,
  // Device outputs
  input wire logic        bridge_gate_output_o,
  input wire logic        reverse_gate_output_o,
  input wire logic [2:0]  phase_gate_output_o,
  input wire logic        charge_pump_run_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);
  logic w1;
  assign w1 = req && wr && addr == 5'h01;
  property p_brg_on;
    w1 && wdata[0] && !wdata[1] |=> bridge_gate_output_o;
  endproperty
  a_brg_on: assert property (p_brg_on) else $error("bridge not on");
  property p_brg_off;
    w1 && !wdata[0] && !wdata[1] |=> !bridge_gate_output_o;
  endproperty
  a_brg_off: assert property (p_brg_off) else $error("bridge on");
  property p_rev_on;
    w1 && wdata[2] && !wdata[3] |=> reverse_gate_output_o;
  endproperty
  a_rev_on: assert property (p_rev_on) else $error("reverse off");
  property p_rev_off;
    w1 && !wdata[2] && !wdata[3] |=> !reverse_gate_output_o;
  endproperty
  a_rev_off: assert property (p_rev_off) else $error("reverse on");
  property p_ph_on;
    w1 && wdata[4] && !wdata[7] |=> phase_gate_output_o[0];
  endproperty
  a_ph_on: assert property (p_ph_on) else $error("phase off");
  property p_ph_off;
    w1 && !wdata[6] && wdata[9] |=> !phase_gate_output_o[2];
  endproperty
  a_ph_off: assert property (p_ph_off) else $error("phase on");
  property p_cp;
    w1 |=> ##1 charge_pump_run_o == $past(wdata[11], 2);
  endproperty
  a_cp: assert property (p_cp) else $error("pump wrong");
  property p_rd;
    req && !wr && addr < 5'h05 |=> rvalid;
  endproperty
  a_rd: assert property (p_rd) else $error("no read answer");
  c_rd: cover property (req && !wr);
  c_ph: cover property (w1 && wdata[9]);
  c_cp: cover property (w1 && wdata[11]);
endmodule : igw_props

/* igw_tb.sv */
/*
  Testbench: controller and device joined by the link.
  Assumes a 200 MHz clock and a shortened watchdog base count.
*/
module igw_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WDB = 400;
  logic        mclk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [4:0]  addr_i = 5'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        oc_i = 1'b0;
  logic        uv_i = 1'b0;
  logic [15:0] rdata_o;
  wire logic [4:0] gates;
  logic        cp_o;
  logic        dpin_n;
  logic [15:0] r;
  int          n_fail = 0;
  int          checks = 0;
  igw_link_if link ();
  igw_ctrl u_igw_ctrl (.mclk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .link);
  igw_device #(.WD_BASE_CYC(WDB)) u_igw_device (.mclk_i, .nrst_i, .link,
    .bridge_oc_i(oc_i), .bridge_gate_uv_i(uv_i), .reverse_gate_uv_i(uv_i),
    .phase_gate_uv_i({3{uv_i}}), .bridge_gate_output_o(gates[0]),
    .reverse_gate_output_o(gates[1]), .phase_gate_output_o(gates[4:2]),
    .charge_pump_run_o(cp_o), .diagnostic_pin_n_o(dpin_n));
  igw_props u_igw_props (.mclk_i, .nrst_i, .req(link.req), .wr(link.wr),
    .addr(link.addr), .wdata(link.wdata), .rvalid(link.rvalid),
    .bridge_gate_output_o(gates[0]), .reverse_gate_output_o(gates[1]),
    .phase_gate_output_o(gates[4:2]), .charge_pump_run_o(cp_o));
  always #2.5 mclk_i = ~mclk_i;
  task automatic chk(input string nm, input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bw(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    #1;
  endtask : bw
  task automatic br(input logic [4:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : br
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic t_reset;
    chk("gates", 16'h0000, {11'h0, gates});
    chk("pump", 16'h0000, {15'h0, cp_o});
    chk("dpin", 16'h0001, {15'h0, dpin_n});
    br(5'h01, r);
    chk("endis1", 16'h0400, r);
    br(5'h02, r);
    chk("endis2", 16'h0000, r);
    br(5'h1f, r);
    chk("unmapped", 16'h0000, r);
    $display("test reset done");
  endtask : t_reset
  task automatic t_wd;
    repeat (WDB + 20) @(posedge mclk_i);
    br(5'h00, r);
    chk("wd fault", 16'h0001, r);
    chk("dpin", 16'h0000, {15'h0, dpin_n});
    bw(5'h00, 16'h0001);
    br(5'h00, r);
    chk("wd clear", 16'h0000, r);
    bw(5'h03, 16'h0001);
    repeat (WDB / 2 - 40) @(posedge mclk_i);
    br(5'h00, r);
    chk("wd early", 16'h0000, r);
    repeat (WDB / 2 + 20) @(posedge mclk_i);
    br(5'h00, r);
    chk("wd late", 16'h0001, r);
    bw(5'h01, 16'h0000);
    br(5'h01, r);
    chk("wd off", 16'h0000, r);
    bw(5'h00, 16'h0001);
    repeat (WDB + 20) @(posedge mclk_i);
    br(5'h00, r);
    chk("wd quiet", 16'h0000, r);
    $display("test watchdog done");
  endtask : t_wd
  task automatic t_gates;
    logic [15:0] tb [6] = '{16'h0381, 16'h0385, 16'h0314, 16'h02a0,
      16'h0071, 16'h0380};
    foreach (tb[i]) begin
      bw(5'h01, tb[i]);
      chk("gates", {11'h0, tb[i][6:4], tb[i][2] & ~tb[i][3],
        tb[i][0] & ~tb[i][1]}, {11'h0, gates});
    end
    bw(5'h01, 16'h0875);
    @(posedge mclk_i);
    #1;
    chk("pump", 16'h0001, {15'h0, cp_o});
    @(posedge mclk_i);
    oc_i <= 1'b1;
    uv_i <= 1'b1;
    repeat (8) @(posedge mclk_i);
    oc_i <= 1'b0;
    uv_i <= 1'b0;
    #1;
    chk("held", 16'h001f, {11'h0, gates});
    br(5'h00, r);
    chk("flags", 16'h007e, r);
    chk("dpin", 16'h0000, {15'h0, dpin_n});
    bw(5'h00, 16'h007f);
    br(5'h00, r);
    chk("cleared", 16'h0000, r);
    $display("test gates done");
  endtask : t_gates
  task automatic t_oc;
    int n;
    bw(5'h02, 16'h0001);
    bw(5'h01, 16'h0001);
    @(posedge mclk_i);
    oc_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    oc_i <= 1'b0;
    #1;
    chk("isolated", 16'h0000, {15'h0, gates[0]});
    repeat (4) @(posedge mclk_i);
    bw(5'h00, 16'h0002);
    bw(5'h04, 16'h0105);
    bw(5'h01, 16'h1003);
    chk("charging", 16'h0001, {15'h0, gates[0]});
    n = 0;
    while (gates[0] === 1'b1 && n < 100) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    chk("timer", 16'h0001, {15'h0, (n >= 20 && n <= 24)});
    br(5'h00, r);
    chk("oc flag", 16'h0002, r);
    bw(5'h00, 16'h0002);
    bw(5'h01, 16'h1003);
    chk("retry", 16'h0001, {15'h0, gates[0]});
    $display("test overcurrent done");
  endtask : t_oc
  initial begin
    repeat (6) @(posedge mclk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_wd();
    t_gates();
    t_oc();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_fail++;
    give_verdict();
  end
endmodule : igw_tb
